// ### verilog/elh_event_log.v
// Event log hand-off: three offered block slots, handshake register,
// pending count, clear and general scan commands.
// Assumes a Modbus slave front end drives the register port, holds
// REG_REQ until REG_ACK and maps a nonzero REG_EXC to an exception.
`timescale 1ns/1ns
`include "elh_defines.vh"

module elh_event_log (
  input wire SYS_CLK,
  input wire RESETN,
  input wire EVT_VALID,
  input wire [`ELH_ENTRY_W-1:0] EVT_DATA,
  output wire EVT_READY,
  output wire [`ELH_SCAN_AW-1:0] SCAN_INDEX,
  input wire [`ELH_ENTRY_W-1:0] SCAN_DATA,
  output wire SCAN_BUSY,
  input wire REG_REQ,
  input wire REG_WRITE,
  input wire [7:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  output wire REG_ACK,
  output wire [15:0] REG_RDATA,
  output wire [7:0] REG_EXC
);

  localparam ST_IDLE = 1'b0;
  localparam ST_FILL = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // State
  reg state_r;
  reg [1:0] off_cnt_r;
  reg [7:0] seq_r;
  reg bump_r;
  reg loaded_r;
  reg ovf_r;
  reg ack_r;
  reg [15:0] rdata_r;
  reg [7:0] exc_r;
  reg [`ELH_ENTRY_W-1:0] blk_r [0:2];

  wire fifo_full;
  wire fifo_empty;
  wire [`ELH_ENTRY_W-1:0] fifo_head;
  wire [`ELH_FIFO_AW:0] fifo_count;
  wire scan_valid;
  wire [`ELH_ENTRY_W-1:0] scan_entry;
  wire scan_ready;
  wire fifo_push;
  wire [`ELH_ENTRY_W-1:0] fifo_in;
  wire fill_pop;
  wire req_take;

  reg [15:0] rdata_nxt;
  reg [7:0] exc_nxt;
  reg do_ack;
  reg do_clr;
  reg do_gs;
  reg [1:0] ack_k;
  reg [1:0] slot;
  reg [2:0] word;
  reg [7:0] rel;
  reg [`ELH_ENTRY_W-1:0] sel_blk;

  ////////////////////////////////////////////////////////////////////
  // Event intake: live events before scan entries, both back-pressured
  assign EVT_READY = ~fifo_full;
  assign scan_ready = ~fifo_full & ~EVT_VALID;
  assign fifo_push = (EVT_VALID | scan_valid) & ~fifo_full;
  assign fifo_in = EVT_VALID ? EVT_DATA : scan_entry;

  assign fill_pop = (state_r == ST_FILL) & (off_cnt_r != `ELH_SLOTS) &
                    ~fifo_empty;

  elh_event_fifo u_fifo (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .push(fifo_push),
    .push_data(fifo_in),
    .pop(fill_pop),
    .clr(do_clr),
    .full(fifo_full),
    .empty(fifo_empty),
    .head(fifo_head),
    .count(fifo_count)
  );

  elh_scan u_scan (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .start(do_gs),
    .busy(SCAN_BUSY),
    .index(SCAN_INDEX),
    .value(SCAN_DATA),
    .valid(scan_valid),
    .entry(scan_entry),
    .ready(scan_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // Register port: requests taken only while the window is stable
  assign req_take = REG_REQ & ~ack_r & (state_r == ST_IDLE);
  assign REG_ACK = ack_r;
  assign REG_RDATA = rdata_r;
  assign REG_EXC = exc_r;

  always @* begin
    rdata_nxt = 16'h0000;
    exc_nxt = `ELH_EXC_NONE;
    do_ack = 1'b0;
    do_clr = 1'b0;
    do_gs = 1'b0;
    ack_k = 2'd0;
    rel = REG_ADDR - `ELH_ADDR_BLK0;
    slot = 2'd0;
    word = rel[2:0];
    sel_blk = blk_r[0];
    if (rel >= `ELH_BLK_WORDS + `ELH_BLK_WORDS) begin
      slot = 2'd2;
      sel_blk = blk_r[2];
    end else if (rel >= `ELH_BLK_WORDS) begin
      slot = 2'd1;
      sel_blk = blk_r[1];
    end
    if (!REG_WRITE) begin
      if (REG_ADDR == `ELH_ADDR_CTRL) begin
        rdata_nxt = {ovf_r, 5'b00000, off_cnt_r, seq_r};
      end else if (REG_ADDR == `ELH_ADDR_COUNT) begin
        rdata_nxt = {12'h000, fifo_count} + {14'h0000, off_cnt_r};
      end else if (REG_ADDR >= `ELH_ADDR_BLK0 &&
                   REG_ADDR <= `ELH_ADDR_LAST) begin
        if (slot < off_cnt_r) begin
          rdata_nxt = sel_blk[{word, 4'h0} +: 16];
        end else if (word == 3'd0) begin
          rdata_nxt = {`ELH_TYPE_INVALID, 8'h00};
        end
      end else begin
        exc_nxt = `ELH_EXC_ADDR;
      end
    end else if (REG_ADDR == `ELH_ADDR_CTRL) begin
      // Bits 13..10 never looked at
      if (REG_WDATA[`ELH_SEQ_MSB:0] == 8'h00) begin
        do_clr = REG_WDATA[`ELH_CLR_BIT];
        do_gs = REG_WDATA[`ELH_GS_BIT];
      end else if (REG_WDATA[`ELH_SEQ_MSB:0] != seq_r) begin
        exc_nxt = `ELH_EXC_VALUE;
      end else begin
        // Clear supersedes the acknowledge it came with
        do_clr = REG_WDATA[`ELH_CLR_BIT];
        do_ack = ~REG_WDATA[`ELH_CLR_BIT];
        do_gs = REG_WDATA[`ELH_GS_BIT];
        if (REG_WDATA[`ELH_CNT_MSB:`ELH_CNT_LSB] > off_cnt_r)
          ack_k = off_cnt_r;
        else
          ack_k = REG_WDATA[`ELH_CNT_MSB:`ELH_CNT_LSB];
      end
    end else begin
      exc_nxt = `ELH_EXC_ADDR;
    end
    if (!req_take) begin
      do_ack = 1'b0;
      do_clr = 1'b0;
      // Clear lands in this cycle, scan entries only from the next
      do_gs = 1'b0;
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
      exc_r <= `ELH_EXC_NONE;
    end else begin
      ack_r <= req_take;
      if (req_take) begin
        rdata_r <= rdata_nxt;
        exc_r <= exc_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Overflow flag: a new overflow beats the clearing acknowledge
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN)
      ovf_r <= 1'b0;
    else if (EVT_VALID & fifo_full)
      ovf_r <= 1'b1;
    else if (do_ack)
      ovf_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Block slots: changed only by acknowledge or an empty window
  integer i;
  always @(posedge SYS_CLK) begin
    if (do_ack) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (i + ack_k < 3)
          blk_r[i] <= blk_r[i + ack_k];
      end
    end else if (fill_pop) begin
      blk_r[off_cnt_r] <= fifo_head;
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      off_cnt_r <= 2'd0;
      seq_r <= `ELH_SEQ_RESET;
      bump_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          loaded_r <= 1'b0;
          if (do_clr) begin
            // Sequence kept; the next load steps it
            off_cnt_r <= 2'd0;
            bump_r <= 1'b0;
          end else if (do_ack) begin
            off_cnt_r <= off_cnt_r - ack_k;
            bump_r <= (ack_k != off_cnt_r) | (ack_k == 2'd0);
            state_r <= ST_FILL;
          end else if (off_cnt_r == 2'd0 && !fifo_empty) begin
            // Nothing offered, so nothing to hold back
            bump_r <= 1'b0;
            state_r <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (fill_pop) begin
            off_cnt_r <= off_cnt_r + 1'b1;
            loaded_r <= 1'b1;
          end else begin
            state_r <= ST_IDLE;
            if (bump_r | loaded_r) begin
              if (seq_r == `ELH_SEQ_MAX)
                seq_r <= `ELH_SEQ_FIRST;
              else
                seq_r <= seq_r + 1'b1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // elh_event_log

// ### verilog/elh_defines.vh
// Constants for the event log hand-off block: register indexes,
// handshake word fields, entry layout, buffer sizes, exception codes.
// Assumes a Modbus slave front end that turns holding-register
// reads and writes into single word requests on the register port.
//
// Operation
// - Written count field gives how many offered entries master evaluated.
// - Zero count keeps current entries offered but still advances sequence.
// - Smaller count drops that many oldest, shifts rest, refills, advances.
// - Equal count drops all offered; advance only if more are pending.
// - Count above offered count acts exactly like the offered count.
// - Reserved bits of a written handshake word are ignored.
// - Scan request bit starts one scan logging each annunciation flagged.
// - Scan request during a running scan is discarded, no restart.
// - Last entry of a scan carries the scan-end flag in bit 39, outside its type byte.
// - Clear bit discards all held entries; pending count reads zero.
// - Clear keeps sequence; next transfer uses the next incremented value.
// - After clear, unacknowledged read entries need no acknowledge.
// - Clear and scan in one write: clear first, then start scan.
// - Up to three entries sit in block registers for one read.
// - Block data stays unchanged until an acknowledge write arrives.
// - Wrong sequence answers exception 03; sequence zero runs commands.
// - Sequence steps 1 to 255 then 1; zero only before first entry.
// - Unused block slot shows register type FF as invalid.
`ifndef ELH_DEFINES_VH
`define ELH_DEFINES_VH

// Register indexes (one holding register each)
`define ELH_ADDR_CTRL 8'h00
`define ELH_ADDR_COUNT 8'h01
`define ELH_ADDR_BLK0 8'h02
`define ELH_ADDR_LAST 8'h19
`define ELH_BLK_WORDS 8'h08

// Handshake word fields
`define ELH_SEQ_MSB 7
`define ELH_CNT_MSB 9
`define ELH_CNT_LSB 8
`define ELH_GS_BIT 14
`define ELH_CLR_BIT 15
`define ELH_SEQ_MAX 8'hff
`define ELH_SEQ_FIRST 8'h01
`define ELH_SEQ_RESET 8'h00

// Entry layout: word n of a block in bits [16n+15:16n]
`define ELH_ENTRY_W 128
`define ELH_TYPE_MSB 15
`define ELH_TYPE_LSB 8
`define ELH_TYPE_INVALID 8'hff
`define ELH_GS_FLAG_BIT 38
`define ELH_GENERAL_SCAN_FINAL_BIT 39

// Sizes
`define ELH_SLOTS 2'd3
`define ELH_FIFO_DEPTH 8
`define ELH_FIFO_AW 3
`define ELH_SCAN_NUM 16
`define ELH_SCAN_AW 4

// Answer codes
`define ELH_EXC_NONE 8'h00
`define ELH_EXC_ADDR 8'h02
`define ELH_EXC_VALUE 8'h03

`endif

// ### verilog/elh_event_fifo.v
// Pending event list behind the three offered block slots.
// Assumes the owner never pushes when full; a pop when empty is ignored.
`timescale 1ns/1ns
`include "elh_defines.vh"

module elh_event_fifo (
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire [`ELH_ENTRY_W-1:0] push_data,
  input wire pop,
  input wire clr,
  output wire full,
  output wire empty,
  output wire [`ELH_ENTRY_W-1:0] head,
  output wire [`ELH_FIFO_AW:0] count
);

  reg [`ELH_ENTRY_W-1:0] mem_r [0:`ELH_FIFO_DEPTH-1];
  reg [`ELH_FIFO_AW-1:0] rd_r;
  reg [`ELH_FIFO_AW-1:0] wr_r;
  reg [`ELH_FIFO_AW:0] cnt_r;
  wire do_pop;

  assign full = (cnt_r == `ELH_FIFO_DEPTH);
  assign empty = (cnt_r == {(`ELH_FIFO_AW+1){1'b0}});
  assign head = mem_r[rd_r];
  assign count = cnt_r;
  assign do_pop = pop & ~empty & ~clr;

  always @(posedge clk) begin
    if (push)
      mem_r[wr_r] <= push_data;
  end

  ////////////////////////////////////////////////////////////////////
  // Clear drops held entries but keeps one arriving in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= {`ELH_FIFO_AW{1'b0}};
      wr_r <= {`ELH_FIFO_AW{1'b0}};
      cnt_r <= {(`ELH_FIFO_AW+1){1'b0}};
    end else if (clr) begin
      rd_r <= wr_r;
      wr_r <= push ? wr_r + 1'b1 : wr_r;
      cnt_r <= push ? 4'h1 : 4'h0;
    end else begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (do_pop)
        rd_r <= rd_r + 1'b1;
      if (push & ~do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule // elh_event_fifo

// ### verilog/elh_scan.v
// General scan sequencer: walks every logged annunciation once and
// offers each present value as a flagged entry.
// Assumes SCAN_DATA answers the index combinationally.
`timescale 1ns/1ns
`include "elh_defines.vh"

module elh_scan (
  input wire clk,
  input wire rst_n,
  input wire start,
  output wire busy,
  output reg [`ELH_SCAN_AW-1:0] index,
  input wire [`ELH_ENTRY_W-1:0] value,
  output wire valid,
  output reg [`ELH_ENTRY_W-1:0] entry,
  input wire ready
);

  // Scan count is a power of two, so the last index is all ones
  localparam [`ELH_SCAN_AW-1:0] LAST_IDX = {`ELH_SCAN_AW{1'b1}};
  reg busy_r;

  assign busy = busy_r;
  assign valid = busy_r;

  always @* begin
    entry = value;
    entry[`ELH_GS_FLAG_BIT] = 1'b1;
    entry[`ELH_GENERAL_SCAN_FINAL_BIT] = (index == LAST_IDX);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      index <= {`ELH_SCAN_AW{1'b0}};
    end else if (!busy_r) begin
      // A start while busy never reaches here, so no restart
      if (start) begin
        busy_r <= 1'b1;
        index <= {`ELH_SCAN_AW{1'b0}};
      end
    end else if (ready) begin
      if (index == LAST_IDX)
        busy_r <= 1'b0;
      else
        index <= index + 1'b1;
    end
  end

endmodule // elh_scan

// ### tb/elh_event_log_monitor.sv
// Port checker for elh_event_log.
// Bound onto the design; sees its ports only.
`timescale 1ns/1ns
module elh_event_log_monitor (
  input wire SYS_CLK,
  input wire RESETN,
  input wire [3:0] SCAN_INDEX,
  input wire SCAN_BUSY,
  input wire REG_REQ,
  input wire REG_WRITE,
  input wire [7:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_ACK,
  input wire [15:0] REG_RDATA,
  input wire [7:0] REG_EXC
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_ack_pulse: assert property (REG_ACK |=> !REG_ACK)
    else $error("ack too long");
  a_ack_cause: assert property (REG_ACK |-> $past(REG_REQ))
    else $error("ack without request");
  a_ack_bound: assert property ($rose(REG_REQ) |-> ##[1:12] REG_ACK)
    else $error("no ack");
  a_bad_addr: assert property (REG_ACK && ($past(REG_ADDR) > 8'h19 ||
    $past(REG_WRITE) && $past(REG_ADDR) != 8'h00) |-> REG_EXC == 8'h02)
    else $error("bad address accepted");
  a_seq_zero: assert property (REG_ACK && $past(REG_WRITE &&
    REG_ADDR == 8'h00 && REG_WDATA[7:0] == 8'h00) |-> REG_EXC == 8'h00)
    else $error("zero sequence refused");
  a_empty_seq: assert property (REG_ACK && $past(!REG_WRITE &&
    REG_ADDR == 8'h00) |-> REG_RDATA[14:10] == 5'h00 &&
    (REG_RDATA[7:0] != 8'h00 || REG_RDATA[9:8] == 2'h0))
    else $error("blocks under zero sequence");
  a_scan_step: assert property (SCAN_BUSY && $past(SCAN_BUSY) &&
    SCAN_INDEX != $past(SCAN_INDEX) |-> SCAN_INDEX - $past(SCAN_INDEX) == 4'h1)
    else $error("scan index skipped");
  a_wr_rdata: assert property (REG_ACK && $past(REG_WRITE) |->
    REG_RDATA == 16'h0000)
    else $error("write returned data");
  c_scan: cover property ($rose(SCAN_BUSY));
  c_seq_err: cover property (REG_ACK && REG_EXC == 8'h03);
  c_addr_err: cover property (REG_ACK && REG_EXC == 8'h02);
endmodule // elh_event_log_monitor

// ### tb/elh_master_model.sv
// Polling register master for the event log register port.
// Shares SYS_CLK with the design; one request at a time.
`timescale 1ns/1ns
module elh_master_model (
  input wire clk,
  input wire ack,
  input wire [15:0] rdata,
  input wire [7:0] exc,
  output reg req = 1'b0,
  output reg wr = 1'b0,
  output reg [7:0] addr = 8'h00,
  output reg [15:0] wdata = 16'h0000
);
  // Request held whole until ack is sampled; ee marks a hang
  task xfer(input bit w, input [7:0] a, input [15:0] d,
    output [15:0] q, output [7:0] e);
    int i;
    begin
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (ack !== 1'b1 && i < 60);
      q = rdata;
      e = (ack === 1'b1) ? exc : 8'hee;
      req <= 1'b0;
    end
  endtask
  // Cyclic poll, repeated freely
  task poll(output [15:0] q, output [7:0] e);
    xfer(1'b0, 8'h00, 16'h0000, q, e);
  endtask
  // Sequence read plus count; commands ride along
  task give(input [7:0] s, input [1:0] c, input [1:0] cmd,
    input [3:0] rsv, output [7:0] e);
    logic [15:0] q;
    xfer(1'b1, 8'h00, {cmd, rsv, c, s}, q, e);
  endtask
endmodule // elh_master_model

// ### tb/elh_event_log_tb_top.sv
// Self-checking bench for elh_event_log against a queue model.
// Needs the design, master model and monitor compiled first.
`timescale 1ns/1ns
module elh_event_log_tb_top;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg evt_valid = 1'b0;
  reg [127:0] evt_data = 128'h0;
  wire evt_ready, scan_busy, req, wr, ack;
  wire [3:0] scan_index;
  wire [127:0] scan_data;
  wire [7:0] addr, exc;
  wire [15:0] wdata, rdata;
  int failures = 0;
  int tests_run = 0;
  logic [127:0] lq[$];
  int off = 0;
  logic [7:0] seq = 8'h00;
  logic [31:0] rs = 32'h8402b6b6;
  logic [31:0] r;
  logic [15:0] q;
  logic [7:0] e;
  always #4 sys_clk = ~sys_clk;
  // Scan values carry their index; flag bits left clear
  assign scan_data = {112'h0, 8'h04, 4'h0, scan_index};
  elh_event_log i_dut (.SYS_CLK(sys_clk), .RESETN(resetn),
    .EVT_VALID(evt_valid), .EVT_DATA(evt_data), .EVT_READY(evt_ready),
    .SCAN_INDEX(scan_index), .SCAN_DATA(scan_data), .SCAN_BUSY(scan_busy),
    .REG_REQ(req), .REG_WRITE(wr), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_ACK(ack), .REG_RDATA(rdata), .REG_EXC(exc));
  elh_master_model i_mst (.clk(sys_clk), .ack(ack), .rdata(rdata),
    .exc(exc), .req(req), .wr(wr), .addr(addr), .wdata(wdata));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] s);
    return (s == 8'hff) ? 8'h01 : s + 8'h01;
  endfunction
  task chk(input string n, input logic [127:0] x, input logic [127:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Only an empty window loads at once; others wait for an ack
  task push();
    logic [127:0] d;
    d = {xs(), xs(), xs(), xs()};
    d[15:8] = 8'h01;
    @(posedge sys_clk);
    evt_valid <= 1'b1;
    evt_data <= d;
    @(posedge sys_clk);
    evt_valid <= 1'b0;
    chk("evt_ready", 1'b1, evt_ready);
    lq.push_back(d);
    if (off == 0) begin
      repeat (4) @(posedge sys_clk);
      off = 1;
      seq = nx(seq);
    end
  endtask
  task ack_blocks(input logic [1:0] c, input logic [1:0] cmd);
    r = xs();
    i_mst.give(seq, c, cmd, r[3:0], e);
    chk("ack_exc", 8'h00, e);
    if (cmd[1]) begin
      lq.delete();
      off = 0;
    end else begin
      repeat ((c > off) ? off : c) void'(lq.pop_front());
      off = (lq.size() > 3) ? 3 : lq.size();
      if (c == 0 || off > 0) seq = nx(seq);
    end
  endtask
  task rdblk(input int k, output logic [127:0] b);
    logic [15:0] d;
    for (int w = 0; w < 8; w++) begin
      i_mst.xfer(1'b0, 8'(2 + 8 * k + w), 16'h0000, d, e);
      b[16 * w +: 16] = d;
    end
  endtask
  task check_all();
    logic [127:0] b;
    i_mst.poll(q, e);
    chk("ctrl", {6'h00, off[1:0], seq}, q);
    i_mst.xfer(1'b0, 8'h01, 16'h0000, q, e);
    chk("count", lq.size(), q);
    for (int k = 0; k < 3; k++) begin
      rdblk(k, b);
      chk("block", (k < off) ? lq[k] : 128'hff00, b);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [127:0] b, x;
    int n;
    logic [7:0] s0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    check_all();
    repeat (5) push();
    check_all();
    ack_blocks(2'd0, 2'b00);
    check_all();
    i_mst.give(nx(seq), 2'd1, 2'b00, 4'h0, e);
    chk("bad_seq", 8'h03, e);
    i_mst.xfer(1'b1, 8'h05, 16'h0001, q, e);
    chk("ro_write", 8'h02, e);
    i_mst.xfer(1'b0, 8'h1a, 16'h0000, q, e);
    chk("bad_addr", 8'h02, e);
    check_all();
    $display("test handshake done");
    for (int i = 0; i < 40; i++) begin
      repeat (xs() % 3) if (lq.size() - off < 8) push();
      r = xs();
      if (off > 0) ack_blocks(r[1:0], 2'b00);
      check_all();
    end
    $display("test random done");
    if (off == 0) push();
    for (int i = 0; i < 260; i++) ack_blocks(2'd0, 2'b00);
    check_all();
    ack_blocks(2'd0, 2'b10);
    check_all();
    push();
    check_all();
    $display("test wrap and clear done");
    repeat (3) push();
    s0 = seq;
    i_mst.give(8'h00, 2'd0, 2'b11, 4'h0, e);
    lq.delete();
    off = 0;
    repeat (4) @(posedge sys_clk);
    chk("scan_busy", 1'b1, scan_busy);
    i_mst.give(8'h00, 2'd0, 2'b01, 4'h0, e);
    n = 0;
    for (int i = 0; i < 200 && n < 16; i++) begin
      i_mst.poll(q, e);
      if (q[9:8] != 2'h0) begin
        if (n == 0) chk("seq_clear", nx(s0), q[7:0]);
        for (int k = 0; k < q[9:8]; k++) begin
          rdblk(k, b);
          x = {112'h0, 8'h04, 4'h0, 4'(n)};
          x[38] = 1'b1;
          x[39] = (n == 15);
          chk("scan_entry", x, b);
          n++;
        end
        seq = q[7:0];
        i_mst.give(q[7:0], q[9:8], 2'b00, 4'h0, e);
      end
    end
    repeat (40) @(posedge sys_clk);
    chk("scan_total", 16, n);
    chk("scan_idle", 1'b0, scan_busy);
    check_all();
    $display("test scan done");
    end_sim();
  end
  initial begin : watchdog
    #480000;
    failures++;
    $display("Error watchdog expected end seen hang");
    end_sim();
  end
endmodule // elh_event_log_tb_top
bind elh_event_log elh_event_log_monitor i_mon (.SYS_CLK(SYS_CLK),
  .RESETN(RESETN), .SCAN_INDEX(SCAN_INDEX), .SCAN_BUSY(SCAN_BUSY),
  .REG_REQ(REG_REQ), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK), .REG_RDATA(REG_RDATA),
  .REG_EXC(REG_EXC));
